/* core/reading_buffer.sv */
/*
 * Reading buffer with fill modes, per-function capacity, running
 * statistics, source-delay-measure sequencing and output on/off delays.
 * Assumes the measurement front end runs on aclk and presents one reading
 * per rd_valid pulse; software configures it over AXI4-Lite.
 */
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - One buffer stores values, status, output state.
// - Keeps sum, squares, min, max statistics.
// - Buffer is empty after power-up.
// - Supply function capacity starts at 100.
// - Battery functions capacity starts at 2500.
// - Capacity changes accepted in supply function only.
// - Capacity change clears readings and statistics.
// - Never mode stores no readings.
// - Next mode stops storing at capacity.
// - Next mode turns to never when full.
// - Always mode wraps and overwrites oldest.
// - Battery functions force always mode.
// - Autoclear empties buffer when storage begins.
// - Window settings honoured only in never mode.
// - Apply level, run delay, then measure.
// - Source delay resets to one millisecond.
// - Source delay 0 to 99 s, 10 us steps.
// - 5.5/6.5 digits force delay on, 1 ms.
// - Output waits rise/fall delay when enabled.
// - Rise and fall delays 1 ms to 10 s.
module reading_buffer
    import rdbuf_pkg::*;
#(
    parameter int unsigned DEPTH = 2500
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic level_set,
    output logic measure_go,
    input wire logic rd_valid,
    input wire logic [15:0] rd_voltage,
    input wire logic [15:0] rd_current,
    input wire logic [7:0] rd_status,
    output logic output_on
);
    localparam int unsigned CW = 12;

    record_t mem [DEPTH];
    fill_t mode;
    func_t func;
    sdm_t source_delay_measure_cycle;
    logic [CW-1:0] cap, count, wr_idx, rd_index;
    logic autoclr, src_en, out_dly_en, out_req;
    logic [2:0] res;
    logic [23:0] src_dly, sdm_cnt, od_cnt;
    logic [13:0] rise_dly, fall_dly;
    logic [15:0] win, vmin, vmax;
    logic [27:0] sum;
    logic [47:0] sumsq;
    logic [11:0] div_cnt;
    logic tick;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic aw_held, w_held, wr_fire;
    logic [1:0] next_mode, next_func;
    logic mapped_w, cap_ok, func_change, start_store, clr_now;
    fill_t eff_mode;
    logic full, store, overwrite, wstrb_ok;
    record_t old_rec, new_rec;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= OFF_RD_DATA1) && (a[1:0] == 2'b00);
    endfunction

    // AXI4-Lite write side: address and data are caught independently.
    assign awready = !aw_held;
    assign wready = !w_held;
    assign wr_fire = aw_held && w_held && !bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_data <= wdata;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // Byte strobes are honoured only as all-or-nothing on the low lane, which keeps decode small.
    assign mapped_w = wr_fire && mapped(aw_addr) && wstrb_ok;
    logic [3:0] strb_held;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            strb_held <= 4'h0;
        else if (wvalid && wready)
            strb_held <= wstrb;
    end
    assign wstrb_ok = strb_held[0];

    assign next_mode = w_data[CTRL_MODE_LSB +: 2];
    assign next_func = w_data[CTRL_FUNC_LSB +: 2];
    assign func_change = mapped_w && aw_addr == OFF_CTRL && next_func != func;
    assign start_store = mapped_w && aw_addr == OFF_CTRL && autoclr
        && (next_mode == FILL_NEXT || next_mode == FILL_ALWAYS);
    assign cap_ok = func == FN_SUPPLY && w_data[CW-1:0] != '0 && w_data[31:CW] == '0
        && w_data[CW-1:0] <= CW'(DEPTH);
    assign clr_now = func_change || start_store || (mapped_w && aw_addr == OFF_CAP && cap_ok)
        || (mapped_w && aw_addr == OFF_CTRL && w_data[CTRL_CLEAR]);

    // Configuration registers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            func <= FN_SUPPLY;
            cap <= CAP_SUPPLY;
            autoclr <= 1'b0;
            src_en <= 1'b1;
            src_dly <= SRC_DLY_DEF;
            out_dly_en <= 1'b0;
            out_req <= 1'b0;
            res <= 3'h4;
            rise_dly <= OUT_DLY_DEF;
            fall_dly <= OUT_DLY_DEF;
            win <= WIN_FULL_VIEW;
            rd_index <= '0;
        end
        else if (mapped_w)
        begin
            case (aw_addr)
                OFF_CTRL:
                begin
                    if (func_change)
                    begin
                        func <= func_t'(next_func);
                        cap <= (next_func == FN_SUPPLY) ? CAP_SUPPLY : CAP_BATT;
                    end
                    autoclr <= w_data[CTRL_AUTOCLR];
                    out_dly_en <= w_data[CTRL_OUT_DLY_EN];
                    out_req <= w_data[CTRL_OUT_REQ];
                    res <= w_data[CTRL_RES_LSB +: 3];
                    if (w_data[CTRL_RES_LSB +: 3] == RES_5P5 || w_data[CTRL_RES_LSB +: 3] == RES_6P5)
                    begin
                        src_en <= 1'b1;
                        src_dly <= SRC_DLY_DEF;
                    end
                    else
                        src_en <= w_data[CTRL_SRC_EN];
                end
                OFF_CAP: if (cap_ok) cap <= w_data[CW-1:0];
                OFF_SRC_DLY: if (w_data <= 32'(SRC_DLY_MAX)) src_dly <= w_data[23:0];
                OFF_RISE_DLY: if (w_data >= 32'(OUT_DLY_MIN) && w_data <= 32'(OUT_DLY_MAX))
                    rise_dly <= w_data[13:0];
                OFF_FALL_DLY: if (w_data >= 32'(OUT_DLY_MIN) && w_data <= 32'(OUT_DLY_MAX))
                    fall_dly <= w_data[13:0];
                OFF_WINDOW: win <= w_data[15:0];
                OFF_RD_INDEX: rd_index <= w_data[CW-1:0];
                default: ;
            endcase
        end
    end

    // Fill mode: software writes win over the automatic switch to never.
    assign eff_mode = (func == FN_SUPPLY) ? mode : FILL_ALWAYS;
    assign full = count == cap;
    assign store = rd_valid && !clr_now && (eff_mode == FILL_ALWAYS || (eff_mode == FILL_NEXT && !full));
    assign overwrite = full && eff_mode == FILL_ALWAYS;
    assign old_rec = mem[wr_idx];
    assign new_rec = '{voltage: rd_voltage, current: rd_current, status: rd_status, out_on: output_on};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mode <= FILL_ALWAYS;
        else if (mapped_w && aw_addr == OFF_CTRL && func == FN_SUPPLY && next_mode != 2'b11)
            mode <= fill_t'(next_mode);
        else if (eff_mode == FILL_NEXT && (full || (store && count + 1'b1 == cap)))
            mode <= FILL_NEVER;
    end

    always_ff @(posedge aclk)
    begin
        if (store)
            mem[wr_idx] <= new_rec;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || clr_now)
        begin
            count <= '0;
            wr_idx <= '0;
        end
        else if (store)
        begin
            wr_idx <= (wr_idx + 1'b1 >= cap) ? '0 : wr_idx + 1'b1;
            if (!full)
                count <= count + 1'b1;
        end
    end

    // The sums drop the overwritten reading so they always cover the held readings.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || clr_now)
        begin
            sum <= '0;
            sumsq <= '0;
            vmin <= 16'hFFFF;
            vmax <= 16'h0000;
        end
        else if (store)
        begin
            sum <= sum + 28'(rd_voltage) - (overwrite ? 28'(old_rec.voltage) : 28'h0);
            sumsq <= sumsq + 48'(rd_voltage) * 48'(rd_voltage)
                - (overwrite ? 48'(old_rec.voltage) * 48'(old_rec.voltage) : 48'h0);
            if (rd_voltage < vmin) vmin <= rd_voltage;
            if (rd_voltage > vmax) vmax <= rd_voltage;
        end
    end

    // Shared 10 us tick; both delay timers count one tick past target so the wait is never short.
    assign tick = div_cnt == 12'(TICK_CYC - 1);
    always_ff @(posedge aclk)
    begin
        if (!aresetn || tick)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            source_delay_measure_cycle <= SDM_IDLE;
            sdm_cnt <= '0;
            measure_go <= 1'b0;
        end
        else
        begin
            measure_go <= 1'b0;
            case (source_delay_measure_cycle)
                SDM_IDLE:
                    if (level_set)
                    begin
                        sdm_cnt <= '0;
                        if (src_en && src_dly != '0)
                            source_delay_measure_cycle <= SDM_DELAY;
                        else
                        begin
                            source_delay_measure_cycle <= SDM_MEASURE;
                            measure_go <= 1'b1;
                        end
                    end
                SDM_DELAY:
                    if (sdm_cnt > src_dly)
                    begin
                        source_delay_measure_cycle <= SDM_MEASURE;
                        measure_go <= 1'b1;
                    end
                    else if (tick)
                        sdm_cnt <= sdm_cnt + 1'b1;
                SDM_MEASURE:
                    if (rd_valid)
                        source_delay_measure_cycle <= SDM_IDLE;
                default: source_delay_measure_cycle <= SDM_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            output_on <= 1'b0;
            od_cnt <= '0;
        end
        else if (out_req == output_on)
            od_cnt <= '0;
        else if (!out_dly_en)
            output_on <= out_req;
        else if (od_cnt > 24'((out_req ? rise_dly : fall_dly) * 24'(TICKS_PER_MS)))
        begin
            output_on <= out_req;
            od_cnt <= '0;
        end
        else if (tick)
            od_cnt <= od_cnt + 1'b1;
    end

    // AXI4-Lite read side.
    assign arready = !rvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            case (araddr)
                OFF_CTRL: rdata <= {20'h0, res, out_req, out_dly_en, src_en, 1'b0, autoclr, func, mode};
                OFF_CAP: rdata <= 32'(cap);
                OFF_SRC_DLY: rdata <= 32'(src_dly);
                OFF_RISE_DLY: rdata <= 32'(rise_dly);
                OFF_FALL_DLY: rdata <= 32'(fall_dly);
                OFF_STATUS: rdata <= {11'h0, source_delay_measure_cycle != SDM_IDLE, output_on, eff_mode, full, 4'h0, count};
                OFF_WINDOW: rdata <= {16'h0, eff_mode == FILL_NEVER ? win : WIN_FULL_VIEW};
                OFF_SUM: rdata <= 32'(sum);
                OFF_SUMSQ_LO: rdata <= sumsq[31:0];
                OFF_SUMSQ_HI: rdata <= {16'h0, sumsq[47:32]};
                OFF_MINMAX: rdata <= {vmax, vmin};
                OFF_RD_INDEX: rdata <= 32'(rd_index);
                OFF_RD_DATA0: rdata <= rd_index < cap ? {mem[rd_index].current, mem[rd_index].voltage} : 32'h0;
                OFF_RD_DATA1: rdata <= rd_index < cap ? {23'h0, mem[rd_index].status, mem[rd_index].out_on} : 32'h0;
                default: rdata <= 32'h0000_0000;
            endcase
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_never_no_store: assert property (eff_mode == FILL_NEVER && rd_valid && !clr_now |=> $stable(count))
        else $error("reading stored in never mode");
    a_next_stops: assert property (eff_mode == FILL_NEXT && store && count + 1'b1 == cap && !mapped_w
        |=> mode == FILL_NEVER && full)
        else $error("next mode did not turn to never when full");
    a_cap_clears: assert property (mapped_w && aw_addr == OFF_CAP && cap_ok |=> count == '0 && sum == '0)
        else $error("capacity change kept readings");
    a_batt_always: assert property (func != FN_SUPPLY |-> eff_mode == FILL_ALWAYS)
        else $error("battery function not in always mode");
    a_count_bound: assert property (count <= cap)
        else $error("count above capacity");
    a_wrap_index: assert property (store && !clr_now && wr_idx == cap - 1'b1 |=> wr_idx == '0)
        else $error("write index did not wrap");
    a_delay_before_go: assert property (source_delay_measure_cycle == SDM_DELAY && sdm_cnt <= src_dly |-> !measure_go ##1 !measure_go
        || sdm_cnt > src_dly)
        else $error("measurement began before source delay expired");
    a_res_forces: assert property (mapped_w && aw_addr == OFF_CTRL && w_data[CTRL_RES_LSB +: 3] == RES_6P5
        |=> src_en && src_dly == SRC_DLY_DEF)
        else $error("resolution did not force source delay");
    a_out_delay: assert property (out_dly_en && $rose(out_req) && !output_on |=> !output_on [*8])
        else $error("output turned on before rise delay");
    a_autoclear: assert property (start_store |=> count == '0)
        else $error("autoclear did not empty buffer");
endmodule

`default_nettype wire

/* core/rdbuf_pkg.sv */
/*
 * Shared constants and types for the reading buffer with its
 * source-delay-measure sequencer and output delay timer.
 * Assumes a single 200 MHz clock and an AXI4-Lite register bus.
 */
package rdbuf_pkg;
    localparam int unsigned CLK_NS = 5;
    localparam int unsigned SRC_STEP_NS = 10000;
    localparam int unsigned TICK_CYC = (SRC_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TICKS_PER_MS = 1000000 / SRC_STEP_NS;

    localparam logic [11:0] CAP_SUPPLY = 12'h064;
    localparam logic [11:0] CAP_BATT = 12'h9C4;
    localparam logic [23:0] SRC_DLY_DEF = 24'h000064;
    localparam logic [23:0] SRC_DLY_MAX = 24'h970FE0;
    localparam logic [13:0] OUT_DLY_MIN = 14'h0001;
    localparam logic [13:0] OUT_DLY_MAX = 14'h2710;
    localparam logic [13:0] OUT_DLY_DEF = 14'h0001;
    localparam logic [2:0] RES_5P5 = 3'h5;
    localparam logic [2:0] RES_6P5 = 3'h6;
    localparam logic [15:0] WIN_FULL_VIEW = 16'h6432;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CAP = 8'h04;
    localparam logic [7:0] OFF_SRC_DLY = 8'h08;
    localparam logic [7:0] OFF_RISE_DLY = 8'h0C;
    localparam logic [7:0] OFF_FALL_DLY = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_WINDOW = 8'h18;
    localparam logic [7:0] OFF_SUM = 8'h1C;
    localparam logic [7:0] OFF_SUMSQ_LO = 8'h20;
    localparam logic [7:0] OFF_SUMSQ_HI = 8'h24;
    localparam logic [7:0] OFF_MINMAX = 8'h28;
    localparam logic [7:0] OFF_RD_INDEX = 8'h2C;
    localparam logic [7:0] OFF_RD_DATA0 = 8'h30;
    localparam logic [7:0] OFF_RD_DATA1 = 8'h34;

    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_FUNC_LSB = 2;
    localparam int unsigned CTRL_AUTOCLR = 4;
    localparam int unsigned CTRL_CLEAR = 5;
    localparam int unsigned CTRL_SRC_EN = 6;
    localparam int unsigned CTRL_OUT_DLY_EN = 7;
    localparam int unsigned CTRL_OUT_REQ = 8;
    localparam int unsigned CTRL_RES_LSB = 9;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {FILL_NEVER = 2'b00, FILL_NEXT = 2'b01, FILL_ALWAYS = 2'b10} fill_t;
    typedef enum logic [1:0] {FN_SUPPLY = 2'b00, FN_BATT_TEST = 2'b01, FN_BATT_SIM = 2'b10} func_t;
    typedef enum logic [1:0] {SDM_IDLE = 2'b00, SDM_DELAY = 2'b01, SDM_MEASURE = 2'b10} sdm_t;

    typedef struct packed {
        logic [15:0] voltage;
        logic [15:0] current;
        logic [7:0] status;
        logic out_on;
    } record_t;
endpackage

/* dv/meas_front_end.sv */
/*
 * Behavioural measurement front end that feeds the reading buffer.
 * Assumes aclk, a synchronous active-low aresetn and the shared package.
 */
`timescale 1ns/10ps
`default_nettype none
module meas_front_end
    import rdbuf_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic measure_go,
    input wire logic push,
    input wire logic [7:0] lat,
    output logic rd_valid,
    output logic [15:0] rd_voltage,
    output logic [15:0] rd_current,
    output logic [7:0] rd_status
);
    logic [15:0] seq;
    logic [8:0] wait_cnt;
    // A sequenced reading is taken only after go, lat cycles late to mimic a slow converter.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wait_cnt <= 9'h000;
        else if (measure_go)
            wait_cnt <= {1'b0, lat} + 9'h001;
        else if (wait_cnt != 9'h000)
            wait_cnt <= wait_cnt - 9'h001;
    end
    // Idle data lines flip every cycle so a stale value never passes for a fresh one.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_valid <= 1'b0;
            seq <= 16'h0001;
            rd_voltage <= 16'h0000;
            rd_current <= 16'h0000;
            rd_status <= 8'h00;
        end
        else if (push || wait_cnt == 9'h001)
        begin
            rd_valid <= 1'b1;
            rd_voltage <= seq;
            rd_current <= ~seq;
            rd_status <= seq[7:0];
            seq <= seq + 16'h0001;
        end
        else
        begin
            rd_valid <= 1'b0;
            rd_voltage <= ~rd_voltage;
            rd_current <= ~rd_current;
            rd_status <= ~rd_status;
        end
    end
endmodule
`default_nettype wire

/* dv/reading_buffer_tb_top.sv */
/*
 * Self-checking bench for the reading buffer: AXI4-Lite master tasks and scenarios.
 * Assumes the front end model in meas_front_end.sv and the shared package.
 */
`timescale 1ns/10ps
`default_nettype none
module reading_buffer_tb_top
    import rdbuf_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, level_set, measure_go, rd_valid, output_on, push;
    logic [7:0] awaddr, araddr, rd_status, lat;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] rd_voltage, rd_current, vseq;
    int err_total, n_tests;

    reading_buffer #(.DEPTH(2500)) dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .level_set(level_set), .measure_go(measure_go),
        .rd_valid(rd_valid), .rd_voltage(rd_voltage), .rd_current(rd_current), .rd_status(rd_status),
        .output_on(output_on));
    meas_front_end fe_u (.aclk(aclk), .aresetn(aresetn), .measure_go(measure_go), .push(push), .lat(lat),
        .rd_valid(rd_valid), .rd_voltage(rd_voltage), .rd_current(rd_current), .rd_status(rd_status));

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic hang(input int n, input int lim);
        if (n >= lim)
        begin
            err_total++;
            $display("[FAIL] %0t wait bound used up", $time);
            complete_run();
        end
    endtask

    // The slave may take address and data on different edges, so each is dropped on its own ready.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic b;
        n = 0;
        b = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b && n < 2000)
        begin
            @(posedge aclk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                b = 1'b1;
                r = bresp;
            end
        end
        bready <= 1'b0;
        hang(n, 2000);
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
        int n;
        logic got;
        logic [31:0] d;
        n = 0;
        got = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got && n < 2000)
        begin
            @(posedge aclk);
            n++;
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                got = 1'b1;
                d = rdata;
            end
        end
        rready <= 1'b0;
        hang(n, 2000);
        chk(d & m, e, s);
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] f, input logic [7:0] x);
        return {20'h00000, x, f, m};
    endfunction

    task automatic push_n(input int n);
        @(posedge aclk);
        push <= 1'b1;
        repeat (n) @(posedge aclk);
        push <= 1'b0;
        vseq = vseq + 16'(n);
        repeat (3) @(posedge aclk);
    endtask

    task automatic sdm_run(output int n);
        @(posedge aclk);
        level_set <= 1'b1;
        @(posedge aclk);
        level_set <= 1'b0;
        n = 0;
        while (measure_go !== 1'b1 && n < 8000)
        begin
            @(posedge aclk);
            n++;
        end
        hang(n, 8000);
        repeat (40) @(posedge aclk);
    endtask

    task automatic t_reset();
        rchk(OFF_STATUS, 32'h00000FFF, 32'h00000000, "count at reset");
        rchk(OFF_CAP, 32'h00000FFF, {20'h00000, CAP_SUPPLY}, "capacity at reset");
        rchk(OFF_SRC_DLY, 32'h00FFFFFF, {8'h00, SRC_DLY_DEF}, "source delay at reset");
        $display("test reset done");
    endtask

    task automatic t_next();
        logic [15:0] b;
        w(OFF_CAP, 32'h00000004);
        w(OFF_CTRL, ctl(2'h1, 2'h0, 8'h00));
        b = vseq;
        push_n(6);
        rchk(OFF_STATUS, 32'h00070FFF, 32'h00010004, "next stops full");
        rchk(OFF_SUM, 32'hFFFFFFFF, {16'h0000, b} * 32'h00000004 + 32'h00000006, "sum");
        rchk(OFF_MINMAX, 32'hFFFFFFFF, {b + 16'h0003, b}, "min max");
        w(OFF_CAP, 32'h00000005);
        rchk(OFF_STATUS, 32'h00000FFF, 32'h00000000, "resize count");
        rchk(OFF_SUM, 32'hFFFFFFFF, 32'h00000000, "resize sum");
        w(OFF_CTRL, ctl(2'h0, 2'h0, 8'h00));
        push_n(3);
        rchk(OFF_STATUS, 32'h00000FFF, 32'h00000000, "never stores");
        w(OFF_WINDOW, 32'h00001932);
        rchk(OFF_WINDOW, 32'h0000FFFF, 32'h00001932, "window in never");
        $display("test next and never done");
    endtask

    task automatic t_wrap();
        logic [15:0] b;
        logic [15:0] v3;
        w(OFF_CAP, 32'h00000003);
        w(OFF_CTRL, ctl(2'h2, 2'h0, 8'h00));
        b = vseq;
        v3 = b + 16'h0003;
        push_n(5);
        rchk(OFF_STATUS, 32'h00070FFF, 32'h00050003, "always saturates");
        rchk(OFF_WINDOW, 32'h0000FFFF, {16'h0000, WIN_FULL_VIEW}, "window ignored");
        w(OFF_RD_INDEX, 32'h00000000);
        rchk(OFF_RD_DATA0, 32'hFFFFFFFF, {~v3, v3}, "slot 0 overwritten");
        rchk(OFF_RD_DATA1, 32'h000001FF, {23'h000000, v3[7:0], 1'b0}, "slot 0 status");
        rchk(OFF_SUM, 32'hFFFFFFFF, {16'h0000, b} * 32'h00000003 + 32'h00000009, "sum drops oldest");
        w(OFF_CTRL, ctl(2'h2, 2'h0, 8'h01));
        w(OFF_CTRL, ctl(2'h2, 2'h0, 8'h01));
        rchk(OFF_STATUS, 32'h00000FFF, 32'h00000000, "autoclear");
        $display("test wrap and autoclear done");
    endtask

    task automatic t_batt();
        w(OFF_CTRL, ctl(2'h1, 2'h1, 8'h00));
        rchk(OFF_CAP, 32'h00000FFF, {20'h00000, CAP_BATT}, "battery test capacity");
        rchk(OFF_STATUS, 32'h00060000, 32'h00040000, "battery forces always");
        w(OFF_CAP, 32'h00000032);
        rchk(OFF_CAP, 32'h00000FFF, {20'h00000, CAP_BATT}, "resize refused");
        w(OFF_CTRL, ctl(2'h2, 2'h2, 8'h00));
        rchk(OFF_CAP, 32'h00000FFF, {20'h00000, CAP_BATT}, "battery sim capacity");
        w(OFF_CTRL, ctl(2'h2, 2'h0, 8'h00));
        $display("test battery done");
    endtask

    task automatic t_sdm();
        int n;
        logic [1:0] r;
        w(OFF_SRC_DLY, 32'h00000001);
        w(OFF_CTRL, ctl(2'h2, 2'h0, 8'h04));
        lat <= 8'h14;
        sdm_run(n);
        chk({31'h00000000, n >= 2000 && n <= 6004}, 32'h00000001, "delayed go");
        w(OFF_CTRL, ctl(2'h2, 2'h0, 8'h00));
        lat <= 8'h00;
        sdm_run(n);
        chk({31'h00000000, n <= 2}, 32'h00000001, "undelayed go");
        rchk(OFF_STATUS, 32'h00000FFF, 32'h00000002, "sequenced readings");
        for (int i = 5; i < 7; i++)
        begin
            w(OFF_SRC_DLY, 32'h00000000);
            w(OFF_CTRL, ctl(2'h2, 2'h0, {3'(i), 5'h00}));
            rchk(OFF_SRC_DLY, 32'h00FFFFFF, {8'h00, SRC_DLY_DEF}, "resolution delay");
            rchk(OFF_CTRL, 32'h00000040, 32'h00000040, "resolution enable");
        end
        w(OFF_SRC_DLY, {8'h00, SRC_DLY_MAX});
        w(OFF_SRC_DLY, {8'h00, SRC_DLY_MAX} + 32'h00000001);
        rchk(OFF_SRC_DLY, 32'h00FFFFFF, {8'h00, SRC_DLY_MAX}, "delay range");
        wr(8'h3C, 32'h00000001, r);
        chk({30'h00000000, r}, {30'h00000000, RESP_SLVERR}, "unmapped write");
        $display("test source delay done");
    endtask

    task automatic t_out();
        w(OFF_RISE_DLY, 32'h00000000);
        rchk(OFF_RISE_DLY, 32'h00003FFF, {18'h00000, OUT_DLY_DEF}, "rise below range");
        w(OFF_FALL_DLY, {18'h00000, OUT_DLY_MAX} + 32'h00000001);
        rchk(OFF_FALL_DLY, 32'h00003FFF, {18'h00000, OUT_DLY_DEF}, "fall above range");
        w(OFF_FALL_DLY, {18'h00000, OUT_DLY_MAX});
        rchk(OFF_FALL_DLY, 32'h00003FFF, {18'h00000, OUT_DLY_MAX}, "fall at max");
        w(OFF_CTRL, ctl(2'h2, 2'h0, 8'h10));
        repeat (2) @(posedge aclk);
        chk({31'h00000000, output_on}, 32'h00000001, "output on undelayed");
        w(OFF_CTRL, ctl(2'h2, 2'h0, 8'h00));
        repeat (2) @(posedge aclk);
        w(OFF_CTRL, ctl(2'h2, 2'h0, 8'h18));
        // The 1 ms rise delay is far beyond this wait, so the output must still be off.
        repeat (1000) @(posedge aclk);
        rchk(OFF_STATUS, 32'h00080000, 32'h00000000, "output held by delay");
        $display("test output delay done");
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, level_set, push} = 8'h00;
        {awaddr, araddr, lat, wdata} = 56'h0;
        wstrb = 4'hF;
        vseq = 16'h0001;
        err_total = 0;
        n_tests = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_next();
        t_wrap();
        t_batt();
        t_sdm();
        t_out();
        complete_run();
    end
endmodule
`default_nettype wire
